//--- opdec_pkg.sv
// Purpose: Shared constants and carriers for the S-to-W opcode decoder and executor.
// Assumes: 8-bit core, single clock, binary arithmetic only.
// Notes: Opcode values and flag positions live here; decoder and bench also pick raw opcode bits, the bench raw flag bits.
// Behaviour
// RULE_01 - Subtract with borrow: A minus operand minus not carry; flags N V Z C.
// RULE_02 - Eight zero-page set-bit opcodes 87 to F7 step 16, set chosen bit.
// RULE_03 - Halt opcode DB stops the core clock and freezes execution, flags kept.
// RULE_04 - Store X in absolute, zero-page and zero-page-Y modes, flags kept.
// RULE_05 - Store Y in absolute, zero-page and zero-page-X modes, flags kept.
// RULE_06 - Store zero writes 00 in four modes, flags kept.
// RULE_07 - Copy A to X, set N and Z from result.
// RULE_08 - Copy A to Y, set N and Z from result.
// RULE_09 - Test-reset bits clears in memory bits set in A; only Z changes.
// RULE_10 - Test-set bits ORs A into memory and writes back; only Z changes.
// RULE_11 - Copy S to X, X to A, Y to A, each setting N and Z.
// RULE_12 - Copy X to S with no flag change.
// RULE_13 - Wait opcode pulls the wait line low and suspends execution, flags kept.
// RULE_14 - Shift left puts original bit 7 into carry.
// RULE_15 - Bit test copies operand bit 7 to N and bit 6 to V.
// RULE_16 - Shift right puts original bit 0 into carry.
// RULE_17 - Rotate left puts original bit 7 into carry.
// RULE_18 - Rotate right puts original bit 0 into carry.
// RULE_19 - Test-set/reset Z comes from A AND original memory byte.
package opdec_pkg;

  localparam logic [7:0] OP_SBC_ABS = 8'hED;
  localparam logic [7:0] OP_SBC_ABX = 8'hFD;
  localparam logic [7:0] OP_SBC_ABY = 8'hF9;
  localparam logic [7:0] OP_SBC_IMM = 8'hE9;
  localparam logic [7:0] OP_SBC_ZP = 8'hE5;
  localparam logic [7:0] OP_SBC_ZPXI = 8'hE1;
  localparam logic [7:0] OP_SBC_ZPX = 8'hF5;
  localparam logic [7:0] OP_SBC_ZPI = 8'hF2;
  localparam logic [7:0] OP_SBC_ZPIY = 8'hF1;
  localparam logic [3:0] OP_SMB_LOW = 4'h7;
  localparam logic [3:0] OP_SMB_HI_MIN = 4'h8;
  localparam logic [7:0] OP_HALT = 8'hDB;
  localparam logic [7:0] OP_STX_ABS = 8'h8E;
  localparam logic [7:0] OP_STX_ZP = 8'h86;
  localparam logic [7:0] OP_STX_ZPY = 8'h96;
  localparam logic [7:0] OP_STY_ABS = 8'h8C;
  localparam logic [7:0] OP_STY_ZP = 8'h84;
  localparam logic [7:0] OP_STY_ZPX = 8'h94;
  localparam logic [7:0] OP_STZ_ABS = 8'h9C;
  localparam logic [7:0] OP_STZ_ABX = 8'h9E;
  localparam logic [7:0] OP_STZ_ZP = 8'h64;
  localparam logic [7:0] OP_STZ_ZPX = 8'h74;
  localparam logic [7:0] OP_TAX = 8'hAA;
  localparam logic [7:0] OP_TAY = 8'hA8;
  localparam logic [7:0] OP_TRB_ABS = 8'h1C;
  localparam logic [7:0] OP_TRB_ZP = 8'h14;
  localparam logic [7:0] OP_TSB_ABS = 8'h0C;
  localparam logic [7:0] OP_TSB_ZP = 8'h04;
  localparam logic [7:0] OP_TSX = 8'hBA;
  localparam logic [7:0] OP_TXA = 8'h8A;
  localparam logic [7:0] OP_TXS = 8'h9A;
  localparam logic [7:0] OP_TYA = 8'h98;
  localparam logic [7:0] OP_WAIT = 8'hCB;
  localparam logic [7:0] OP_ASL_ACC = 8'h0A;
  localparam logic [7:0] OP_ASL_ABS = 8'h0E;
  localparam logic [7:0] OP_ASL_ABX = 8'h1E;
  localparam logic [7:0] OP_ASL_ZP = 8'h06;
  localparam logic [7:0] OP_ASL_ZPX = 8'h16;
  localparam logic [7:0] OP_LSR_ACC = 8'h4A;
  localparam logic [7:0] OP_LSR_ABS = 8'h4E;
  localparam logic [7:0] OP_LSR_ABX = 8'h5E;
  localparam logic [7:0] OP_LSR_ZP = 8'h46;
  localparam logic [7:0] OP_LSR_ZPX = 8'h56;
  localparam logic [7:0] OP_ROL_ACC = 8'h2A;
  localparam logic [7:0] OP_ROL_ABS = 8'h2E;
  localparam logic [7:0] OP_ROL_ABX = 8'h3E;
  localparam logic [7:0] OP_ROL_ZP = 8'h26;
  localparam logic [7:0] OP_ROL_ZPX = 8'h36;
  localparam logic [7:0] OP_ROR_ACC = 8'h6A;
  localparam logic [7:0] OP_ROR_ABS = 8'h6E;
  localparam logic [7:0] OP_ROR_ABX = 8'h7E;
  localparam logic [7:0] OP_ROR_ZP = 8'h66;
  localparam logic [7:0] OP_ROR_ZPX = 8'h76;
  localparam logic [7:0] OP_BIT_ABS = 8'h2C;
  localparam logic [7:0] OP_BIT_ZP = 8'h24;

  localparam int FLAG_N = 7;
  localparam int FLAG_V = 6;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  localparam int MSB = 7;
  localparam int BIT6 = 6;
  localparam int LSB = 0;

  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h34;
  localparam logic [7:0] STACK_RESET = 8'hFF;

  localparam logic [15:0] APB_ADDR_OP = 16'h0000;
  localparam logic [15:0] APB_ADDR_OPERAND = 16'h0004;
  localparam logic [15:0] APB_ADDR_ACC = 16'h0008;
  localparam logic [15:0] APB_ADDR_XIDX = 16'h000C;
  localparam logic [15:0] APB_ADDR_YIDX = 16'h0010;
  localparam logic [15:0] APB_ADDR_SPTR = 16'h0014;
  localparam logic [15:0] APB_ADDR_STATUS = 16'h0018;
  localparam logic [15:0] APB_ADDR_MEMOUT = 16'h001C;
  localparam logic [15:0] APB_ADDR_RUN = 16'h0020;
  localparam logic [15:0] APB_ADDR_RESUME = 16'h0024;

  typedef enum logic [1:0] {
    RUN_ACTIVE = 2'b00,
    RUN_HALTED = 2'b01,
    RUN_WAITING = 2'b10
  } run_state_t;

  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_SBC = 4'h1, K_SMB = 4'h2, K_STX = 4'h3, K_STY = 4'h4,
    K_STZ = 4'h5, K_XFER_NZ = 4'h6, K_TXS = 4'h7, K_TRB = 4'h8, K_TSB = 4'h9,
    K_SHIFT = 4'hA, K_BIT = 4'hB, K_HALT = 4'hC, K_WAIT = 4'hD
  } op_kind_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] xidx;
    logic [7:0] yidx;
    logic [7:0] sptr;
    logic [7:0] status;
  } cpu_regs_t;

  typedef struct packed {
    op_kind_t kind;
    logic [1:0] dst;
    logic [1:0] src;
    logic [1:0] shift_sel;
    logic mem_dst;
    logic [2:0] bit_sel;
  } dec_t;

endpackage : opdec_pkg

//--- opcode_decoder.sv
// Purpose: Map an opcode byte to an operation kind and its selectors.
// Assumes: Purely combinational; opcodes outside this group decode to K_NONE.
// Notes: dst/src select 0=A 1=X 2=Y 3=S; shift_sel 0=SHIFT_LEFT_OP 1=SHIFT_RIGHT_OP 2=ROTATE_LEFT_OP 3=ROTATE_RIGHT_OP.
`timescale 1ns/1ps
module opcode_decoder
  import opdec_pkg::*;
(
  input wire logic [7:0] opcode,
  output dec_t dec
);

  always_comb begin
    dec = '{kind: K_NONE, dst: 2'd0, src: 2'd0, shift_sel: 2'd0, mem_dst: 1'b0,
            bit_sel: 3'd0};
    if (opcode[3:0] == OP_SMB_LOW && opcode[7:4] >= OP_SMB_HI_MIN) begin
      dec.kind = K_SMB; // [RULE_02]
      dec.bit_sel = 3'(opcode[6:4]);
    end else begin
      unique case (opcode)
        OP_SBC_ABS, OP_SBC_ABX, OP_SBC_ABY, OP_SBC_IMM, OP_SBC_ZP, OP_SBC_ZPXI,
        OP_SBC_ZPX, OP_SBC_ZPI, OP_SBC_ZPIY: dec.kind = K_SBC; // [RULE_01]
        OP_HALT: dec.kind = K_HALT; // [RULE_03]
        OP_STX_ABS, OP_STX_ZP, OP_STX_ZPY: dec.kind = K_STX; // [RULE_04]
        OP_STY_ABS, OP_STY_ZP, OP_STY_ZPX: dec.kind = K_STY; // [RULE_05]
        OP_STZ_ABS, OP_STZ_ABX, OP_STZ_ZP, OP_STZ_ZPX: dec.kind = K_STZ; // [RULE_06]
        OP_TAX: begin
          dec.kind = K_XFER_NZ; // [RULE_07]
          dec.dst = 2'd1;
          dec.src = 2'd0;
        end
        OP_TAY: begin
          dec.kind = K_XFER_NZ; // [RULE_08]
          dec.dst = 2'd2;
          dec.src = 2'd0;
        end
        OP_TSX: begin
          dec.kind = K_XFER_NZ; // [RULE_11]
          dec.dst = 2'd1;
          dec.src = 2'd3;
        end
        OP_TXA: begin
          dec.kind = K_XFER_NZ; // [RULE_11]
          dec.dst = 2'd0;
          dec.src = 2'd1;
        end
        OP_TYA: begin
          dec.kind = K_XFER_NZ; // [RULE_11]
          dec.dst = 2'd0;
          dec.src = 2'd2;
        end
        OP_TXS: dec.kind = K_TXS; // [RULE_12]
        OP_TRB_ABS, OP_TRB_ZP: dec.kind = K_TRB; // [RULE_09]
        OP_TSB_ABS, OP_TSB_ZP: dec.kind = K_TSB; // [RULE_10]
        OP_WAIT: dec.kind = K_WAIT; // [RULE_13]
        OP_BIT_ABS, OP_BIT_ZP: dec.kind = K_BIT; // [RULE_15]
        // Opcode bit 6 means rightward and bit 5 means rotate; swap them for shift_sel
        OP_ASL_ACC, OP_LSR_ACC, OP_ROL_ACC, OP_ROR_ACC: begin
          dec.kind = K_SHIFT;
          dec.shift_sel = {opcode[5], opcode[6]}; // [RULE_14] [RULE_16] [RULE_17] [RULE_18]
        end
        OP_ASL_ABS, OP_ASL_ABX, OP_ASL_ZP, OP_ASL_ZPX, OP_LSR_ABS, OP_LSR_ABX,
        OP_LSR_ZP, OP_LSR_ZPX, OP_ROL_ABS, OP_ROL_ABX, OP_ROL_ZP, OP_ROL_ZPX,
        OP_ROR_ABS, OP_ROR_ABX, OP_ROR_ZP, OP_ROR_ZPX: begin
          dec.kind = K_SHIFT;
          dec.shift_sel = {opcode[5], opcode[6]}; // [RULE_14] [RULE_16] [RULE_17] [RULE_18]
          dec.mem_dst = 1'b1;
        end
        default: dec.kind = K_NONE;
      endcase
    end
  end

endmodule : opcode_decoder

//--- shift_unit.sv
// Purpose: Shift and rotate one byte, producing result and new carry.
// Assumes: sel 0=shift left, 1=shift right, 2=rotate left, 3=rotate right.
// Notes: Combinational.
`timescale 1ns/1ps
module shift_unit
  import opdec_pkg::*;
(
  input wire logic [7:0] din,
  input wire logic [1:0] sel,
  input wire logic cin,
  output logic [7:0] dout,
  output logic cout
);

  always_comb begin
    unique case (sel)
      2'd0: begin
        dout = {din[6:0], 1'b0};
        cout = din[MSB]; // [RULE_14]
      end
      2'd1: begin
        dout = {1'b0, din[7:1]};
        cout = din[LSB]; // [RULE_16]
      end
      2'd2: begin
        dout = {din[6:0], cin};
        cout = din[MSB]; // [RULE_17]
      end
      2'd3: begin
        dout = {cin, din[7:1]};
        cout = din[LSB]; // [RULE_18]
      end
    endcase
  end

endmodule : shift_unit

//--- opcode_exec.sv
// Purpose: Execute S-to-W opcodes on the register set, driven over APB.
// Assumes: Software writes operand then opcode; opcode write starts one execution.
// Notes: Memory results appear in the mem-out register with a memwr_ff flag that holds until that register is read.
`timescale 1ns/1ps
module opcode_exec
  import opdec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wait_n_o,
  output logic wait_n_oe,
  output logic clk_halted
);

  dec_t dec;
  cpu_regs_t regs_ff;
  cpu_regs_t nxt_regs;
  run_state_t run_ff;
  logic [7:0] opcode_ff;
  logic [7:0] operand_ff;
  logic [7:0] memout_ff;
  logic [7:0] nxt_memout;
  logic memwr_ff;
  logic nxt_memwr;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic shift_c;
  logic [8:0] diff;
  logic [7:0] xfer_val;
  logic wr_en;
  logic rd_en;
  logic exec_go;
  logic addr_ok;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      APB_ADDR_OP, APB_ADDR_OPERAND, APB_ADDR_ACC, APB_ADDR_XIDX, APB_ADDR_YIDX,
      APB_ADDR_SPTR, APB_ADDR_STATUS, APB_ADDR_MEMOUT, APB_ADDR_RUN,
      APB_ADDR_RESUME: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;
  // Opcodes are accepted only while running; halted and waiting cores ignore them
  assign exec_go = wr_en && paddr == APB_ADDR_OP && run_ff == RUN_ACTIVE; // [RULE_03]

  opcode_decoder u_dec (
    .opcode(pwdata[7:0]),
    .dec(dec)
  );

  assign shift_in = dec.mem_dst ? operand_ff : regs_ff.acc;

  shift_unit u_shift (
    .din(shift_in),
    .sel(dec.shift_sel),
    .cin(regs_ff.status[FLAG_C]),
    .dout(shift_out),
    .cout(shift_c)
  );

  // Borrow is the inverted carry
  assign diff = {1'b0, regs_ff.acc} - {1'b0, operand_ff} - {8'h00, !regs_ff.status[FLAG_C]};

  always_comb begin
    unique case (dec.src)
      2'd0: xfer_val = regs_ff.acc;
      2'd1: xfer_val = regs_ff.xidx;
      2'd2: xfer_val = regs_ff.yidx;
      2'd3: xfer_val = regs_ff.sptr;
    endcase
  end

  always_comb begin
    nxt_regs = regs_ff;
    nxt_memout = memout_ff;
    nxt_memwr = 1'b0;
    if (exec_go) begin
      unique case (dec.kind)
        K_SBC: begin
          nxt_regs.acc = diff[7:0]; // [RULE_01]
          nxt_regs.status[FLAG_N] = diff[MSB];
          nxt_regs.status[FLAG_Z] = diff[7:0] == ZERO_BYTE;
          nxt_regs.status[FLAG_C] = !diff[8];
          nxt_regs.status[FLAG_V] = (regs_ff.acc[MSB] ^ operand_ff[MSB])
                                    & (regs_ff.acc[MSB] ^ diff[MSB]);
        end
        K_SMB: begin
          nxt_memout = operand_ff | (8'h01 << dec.bit_sel); // [RULE_02]
          nxt_memwr = 1'b1;
        end
        K_STX: begin
          nxt_memout = regs_ff.xidx; // [RULE_04]
          nxt_memwr = 1'b1;
        end
        K_STY: begin
          nxt_memout = regs_ff.yidx; // [RULE_05]
          nxt_memwr = 1'b1;
        end
        K_STZ: begin
          nxt_memout = ZERO_BYTE; // [RULE_06]
          nxt_memwr = 1'b1;
        end
        K_XFER_NZ: begin
          unique case (dec.dst)
            2'd0: nxt_regs.acc = xfer_val; // [RULE_11]
            2'd1: nxt_regs.xidx = xfer_val; // [RULE_07]
            2'd2: nxt_regs.yidx = xfer_val; // [RULE_08]
            2'd3: nxt_regs.sptr = xfer_val;
          endcase
          nxt_regs.status[FLAG_N] = xfer_val[MSB];
          nxt_regs.status[FLAG_Z] = xfer_val == ZERO_BYTE;
        end
        K_TXS: nxt_regs.sptr = regs_ff.xidx; // [RULE_12]
        K_TRB: begin
          nxt_memout = operand_ff & ~regs_ff.acc; // [RULE_09]
          nxt_memwr = 1'b1;
          nxt_regs.status[FLAG_Z] = (regs_ff.acc & operand_ff) == ZERO_BYTE; // [RULE_19]
        end
        K_TSB: begin
          nxt_memout = operand_ff | regs_ff.acc; // [RULE_10]
          nxt_memwr = 1'b1;
          nxt_regs.status[FLAG_Z] = (regs_ff.acc & operand_ff) == ZERO_BYTE; // [RULE_19]
        end
        K_SHIFT: begin
          if (dec.mem_dst) begin
            nxt_memout = shift_out;
            nxt_memwr = 1'b1;
          end else begin
            nxt_regs.acc = shift_out;
          end
          nxt_regs.status[FLAG_C] = shift_c; // [RULE_14] [RULE_16] [RULE_17] [RULE_18]
          nxt_regs.status[FLAG_N] = shift_out[MSB];
          nxt_regs.status[FLAG_Z] = shift_out == ZERO_BYTE;
        end
        K_BIT: begin
          nxt_regs.status[FLAG_N] = operand_ff[MSB]; // [RULE_15]
          nxt_regs.status[FLAG_V] = operand_ff[BIT6]; // [RULE_15]
          nxt_regs.status[FLAG_Z] = (regs_ff.acc & operand_ff) == ZERO_BYTE;
        end
        K_HALT, K_WAIT, K_NONE: nxt_regs = regs_ff;
        default: nxt_regs = regs_ff;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regs_ff <= '{acc: ZERO_BYTE, xidx: ZERO_BYTE, yidx: ZERO_BYTE, sptr: STACK_RESET,
                   status: STATUS_RESET};
    end else if (wr_en && run_ff == RUN_ACTIVE) begin
      if (exec_go) begin
        regs_ff <= nxt_regs;
      end else begin
        unique case (paddr)
          APB_ADDR_ACC: regs_ff.acc <= pwdata[7:0];
          APB_ADDR_XIDX: regs_ff.xidx <= pwdata[7:0];
          APB_ADDR_YIDX: regs_ff.yidx <= pwdata[7:0];
          APB_ADDR_SPTR: regs_ff.sptr <= pwdata[7:0];
          APB_ADDR_STATUS: regs_ff.status <= pwdata[7:0];
          default: regs_ff <= regs_ff;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      operand_ff <= ZERO_BYTE;
      opcode_ff <= ZERO_BYTE;
    end else if (wr_en && paddr == APB_ADDR_OPERAND) begin
      operand_ff <= pwdata[7:0];
    end else if (exec_go) begin
      opcode_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memout_ff <= ZERO_BYTE;
      memwr_ff <= 1'b0;
    end else begin
      memout_ff <= nxt_memout;
      memwr_ff <= nxt_memwr || (memwr_ff && !(rd_en && paddr == APB_ADDR_MEMOUT));
    end
  end

  // Halt leaves only reset; wait is released by a write to the resume register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_ff <= RUN_ACTIVE;
    end else begin
      unique case (run_ff)
        RUN_ACTIVE: begin
          if (exec_go && dec.kind == K_HALT) begin
            run_ff <= RUN_HALTED; // [RULE_03]
          end else if (exec_go && dec.kind == K_WAIT) begin
            run_ff <= RUN_WAITING; // [RULE_13]
          end
        end
        RUN_WAITING: begin
          if (wr_en && paddr == APB_ADDR_RESUME) begin
            run_ff <= RUN_ACTIVE;
          end
        end
        RUN_HALTED: run_ff <= RUN_HALTED;
        default: run_ff <= RUN_ACTIVE;
      endcase
    end
  end

  // Wait line is open drain: driven low only while waiting
  assign wait_n_o = 1'b0;
  assign wait_n_oe = run_ff == RUN_WAITING; // [RULE_13]
  assign clk_halted = run_ff == RUN_HALTED; // [RULE_03]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        APB_ADDR_OP: prdata <= {24'h000000, opcode_ff};
        APB_ADDR_OPERAND: prdata <= {24'h000000, operand_ff};
        APB_ADDR_ACC: prdata <= {24'h000000, regs_ff.acc};
        APB_ADDR_XIDX: prdata <= {24'h000000, regs_ff.xidx};
        APB_ADDR_YIDX: prdata <= {24'h000000, regs_ff.yidx};
        APB_ADDR_SPTR: prdata <= {24'h000000, regs_ff.sptr};
        APB_ADDR_STATUS: prdata <= {24'h000000, regs_ff.status};
        APB_ADDR_MEMOUT: prdata <= {23'h000000, memwr_ff, memout_ff};
        APB_ADDR_RUN: prdata <= {30'h00000000, run_ff};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : opcode_exec

//--- opcode_exec_monitor.sv
// Purpose: Port-level checks on the run-state and bus behaviour of the opcode executor.
// Assumes: Single clock domain, zero-wait bus slave; unaligned addresses must get an error response.
// Notes: Attached to every opcode_exec by the bind at the foot of this file.
`timescale 1ns/1ps
module opcode_exec_monitor
  import opdec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wait_n_o,
  input wire logic wait_n_oe,
  input wire logic clk_halted
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic acc_ph;
  logic op_wr;
  assign acc_ph = psel && penable;
  // Opcode write that the core is free to execute
  assign op_wr = acc_ph && pwrite && paddr == APB_ADDR_OP && !clk_halted && !wait_n_oe;

  a_halt_entry: assert property (op_wr && pwdata[7:0] == OP_HALT |=> clk_halted)
    else $error("halt opcode did not stop the core");
  a_halt_sticky: assert property (clk_halted |=> clk_halted)
    else $error("halted core resumed without reset");
  a_halt_cause: assert property ($rose(clk_halted) |-> $past(op_wr && pwdata[7:0] == OP_HALT))
    else $error("core halted without a halt opcode");
  a_wait_entry: assert property (op_wr && pwdata[7:0] == OP_WAIT |=> wait_n_oe)
    else $error("wait opcode did not pull the wait line");
  a_wait_low: assert property (wait_n_oe |-> wait_n_o == 1'b0)
    else $error("wait line driven high");
  a_wait_cause: assert property ($rose(wait_n_oe) |-> $past(op_wr && pwdata[7:0] == OP_WAIT))
    else $error("wait line pulled without a wait opcode");
  a_wait_resume: assert property (acc_ph && pwrite && paddr == APB_ADDR_RESUME && wait_n_oe
    |=> !wait_n_oe)
    else $error("resume write did not leave the wait state");
  a_run_exclusive: assert property (!(clk_halted && wait_n_oe))
    else $error("halted and waiting at once");
  a_bad_addr: assert property (acc_ph |-> pready
    && pslverr == (paddr > APB_ADDR_RESUME || paddr[1:0] != 2'b00))
    else $error("bus error response wrong");
  a_run_readback: assert property (psel && !penable && !pwrite && paddr == APB_ADDR_RUN
    |=> prdata[1:0] == {wait_n_oe, clk_halted})
    else $error("run state read disagrees with outputs");

  c_halt: cover property (op_wr && pwdata[7:0] == OP_HALT);
  c_wait: cover property (op_wr && pwdata[7:0] == OP_WAIT);
  c_slverr: cover property (acc_ph && pslverr);
endmodule : opcode_exec_monitor

bind opcode_exec opcode_exec_monitor opcode_exec_monitor_i (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wait_n_o(wait_n_o), .wait_n_oe(wait_n_oe),
  .clk_halted(clk_halted));

//--- cpu8_opcode_decode_s_to_w_test.sv
// Purpose: Self-checking bench for the opcode executor over its register bus.
// Assumes: Zero-wait slave; operand written before opcode; fixed random seed.
// Notes: A bench-side model predicts registers and the memory byte for every opcode except halt and wait.
`timescale 1ns/1ps
module cpu8_opcode_decode_s_to_w_test;
  import opdec_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wait_n_o;
  logic wait_n_oe;
  logic clk_halted;
  logic err_seen;
  logic [31:0] rd;
  logic [7:0] m_a, m_x, m_y, m_s, m_p, m_mem, opnd;
  logic m_wr;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  opcode_exec opcode_exec_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wait_n_o(wait_n_o), .wait_n_oe(wait_n_oe), .clk_halted(clk_halted));

  always #20 clk = ~clk;

  task automatic complete_run();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  task automatic apb(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rdchk(input logic [15:0] a, input string name, input logic [8:0] exp);
    apb(a, 1'b0, 8'h00);
    chk(name, {23'h000000, exp}, rd);
  endtask : rdchk

  task automatic check_regs();
    rdchk(APB_ADDR_ACC, "acc", {1'b0, m_a});
    rdchk(APB_ADDR_XIDX, "xidx", {1'b0, m_x});
    rdchk(APB_ADDR_YIDX, "yidx", {1'b0, m_y});
    rdchk(APB_ADDR_SPTR, "sptr", {1'b0, m_s});
    rdchk(APB_ADDR_STATUS, "status", {1'b0, m_p});
  endtask : check_regs

  function automatic logic [7:0] nzv(input logic [7:0] v);
    m_p[FLAG_N] = v[MSB];
    m_p[FLAG_Z] = (v == ZERO_BYTE);
    return v;
  endfunction : nzv

  function automatic void st(input logic [7:0] v);
    m_mem = v;
    m_wr = 1'b1;
  endfunction : st

  function automatic logic [7:0] tz(input logic [7:0] v);
    m_p[FLAG_Z] = ((m_a & opnd) == ZERO_BYTE);
    return v;
  endfunction : tz

  // Predicts the effect of one opcode; unknown opcodes leave everything alone
  task automatic model(input logic [7:0] op);
    logic [8:0] t;
    logic [7:0] r;
    logic c;
    m_wr = 1'b0;
    if (op[7:5] == 3'b111 && (op[1:0] == 2'b01 || op == OP_SBC_ZPI)) begin
      t = {1'b0, m_a} - {1'b0, opnd} - {8'h00, ~m_p[FLAG_C]};
      m_p[FLAG_V] = (m_a[7] ^ opnd[7]) & (m_a[7] ^ t[7]);
      m_p[FLAG_C] = ~t[8];
      m_a = nzv(t[7:0]);
    end else if (op[3:0] == 4'h7 && op[7]) begin
      st(opnd | (8'h01 << op[6:4]));
    end else if (!op[7] && (op[3:0] == 4'hA ? !op[4] : op[2:0] == 3'b110)) begin
      r = (op[3:0] == 4'hA) ? m_a : opnd;
      c = op[6] ? r[LSB] : r[MSB];
      case (op[6:5])
        2'b00: r = {r[6:0], 1'b0};
        2'b01: r = {r[6:0], m_p[FLAG_C]};
        2'b10: r = {1'b0, r[7:1]};
        default: r = {m_p[FLAG_C], r[7:1]};
      endcase
      m_p[FLAG_C] = c;
      if (op[3:0] == 4'hA) begin
        m_a = nzv(r);
      end else begin
        st(nzv(r));
      end
    end else begin
      case (op)
        OP_STX_ABS, OP_STX_ZP, OP_STX_ZPY: st(m_x);
        OP_STY_ABS, OP_STY_ZP, OP_STY_ZPX: st(m_y);
        OP_STZ_ABS, OP_STZ_ABX, OP_STZ_ZP, OP_STZ_ZPX: st(ZERO_BYTE);
        OP_TAX: m_x = nzv(m_a);
        OP_TAY: m_y = nzv(m_a);
        OP_TSX: m_x = nzv(m_s);
        OP_TXA: m_a = nzv(m_x);
        OP_TYA: m_a = nzv(m_y);
        OP_TXS: m_s = m_x;
        OP_TRB_ABS, OP_TRB_ZP: st(tz(opnd & ~m_a));
        OP_TSB_ABS, OP_TSB_ZP: st(tz(opnd | m_a));
        OP_BIT_ABS, OP_BIT_ZP: m_p = {opnd[7:6], m_p[5:2], (m_a & opnd) == 8'h00, m_p[0]};
        default: ;
      endcase
    end
  endtask : model

  task automatic run_op(input logic [7:0] op);
    apb(APB_ADDR_ACC, 1'b1, m_a);
    apb(APB_ADDR_XIDX, 1'b1, m_x);
    apb(APB_ADDR_YIDX, 1'b1, m_y);
    apb(APB_ADDR_SPTR, 1'b1, m_s);
    apb(APB_ADDR_STATUS, 1'b1, m_p);
    apb(APB_ADDR_OPERAND, 1'b1, opnd);
    apb(APB_ADDR_OP, 1'b1, op);
    model(op);
    check_regs();
    if (m_wr) begin
      rdchk(APB_ADDR_MEMOUT, "memout", {1'b1, m_mem});
    end
  endtask : run_op

  initial begin
    void'($urandom(32'h5570));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    {m_a, m_x, m_y, m_s, m_p} = {24'h000000, STACK_RESET, STATUS_RESET};
    check_regs();
    {m_a, opnd, m_p} = {8'h80, 8'h01, STATUS_RESET | 8'h01};
    run_op(OP_SBC_IMM);
    {m_a, opnd, m_p} = {8'h00, 8'h00, STATUS_RESET};
    run_op(OP_SBC_ZPIY);
    for (int i = 0; i < 512; i++) begin
      if (i[7:0] != OP_HALT && i[7:0] != OP_WAIT) begin
        {m_a, m_x, m_y, m_s, opnd} = {$urandom, 8'($urandom)};
        m_p = (STATUS_RESET & 8'h3C) | (8'($urandom) & 8'hC3);
        run_op(i[7:0]);
      end
    end
    apb(16'h0040, 1'b1, 8'h5A);
    chk("wr_slverr", 32'h1, {31'h0, err_seen});
    apb(16'h0040, 1'b0, 8'h00);
    chk("rd_unmapped", 32'h1, {rd[30:0], err_seen});
    apb(APB_ADDR_OP, 1'b1, OP_WAIT);
    @(negedge clk);
    chk("wait_oe", 32'h1, {30'h0, wait_n_o, wait_n_oe});
    apb(APB_ADDR_OP, 1'b1, OP_TAX);
    check_regs();
    rdchk(APB_ADDR_RUN, "run", 9'h002);
    apb(APB_ADDR_RESUME, 1'b1, 8'h00);
    @(negedge clk);
    chk("wait_left", 32'h0, {31'h0, wait_n_oe});
    apb(APB_ADDR_OP, 1'b1, OP_HALT);
    @(negedge clk);
    chk("halted", 32'h1, {31'h0, clk_halted});
    apb(APB_ADDR_ACC, 1'b1, ~m_a);
    apb(APB_ADDR_OP, 1'b1, OP_TYA);
    apb(APB_ADDR_RESUME, 1'b1, 8'h00);
    check_regs();
    rdchk(APB_ADDR_RUN, "run", 9'h001);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("halt_cleared", 32'h0, {31'h0, clk_halted});
    {m_a, m_x, m_y, m_s, m_p} = {24'h000000, STACK_RESET, STATUS_RESET};
    check_regs();
    complete_run();
  end
endmodule : cpu8_opcode_decode_s_to_w_test
